// >>> inc/supply_reset_sequencer_map.svh
`ifndef SUPPLY_RESET_SEQUENCER_MAP_SVH
`define SUPPLY_RESET_SEQUENCER_MAP_SVH

// register byte offsets
`define OFS_MODE       8'h00
`define OFS_CTRL       8'h04
`define OFS_STATUS     8'h08
`define OFS_WAKE_EN    8'h0c
`define OFS_IRQ_STAT   8'h10
`define OFS_IRQ_CLR    8'h14
`define OFS_IRQ_EN     8'h18

// supply_mode_register fields
`define MODE_BOD_DIS   0
`define MODE_MON_EN    1
`define MODE_THR_LO    4
`define MODE_THR_HI    7
`define MODE_SMP_LO    8
`define MODE_SMP_HI    11
`define MODE_XTAL_EN   12
`define MODE_SLOW_XTAL 13
`define MODE_LP_BACKUP 16
`define MODE_FRC_LO    20
`define MODE_FRC_HI    21
`define MODE_RESET     32'h0000_0000
`define MODE_WMASK     32'h0031_3ff3
`define MODE_STICKY    32'h0000_2000

// control register bits
`define CTRL_SW_RST    0
`define CTRL_LP_ENTER  1

// status register fields
`define STAT_CAUSE_HI  2
`define STAT_MON_LOW   4
`define STAT_SLOW_XTAL 5
`define STAT_SEQ_LO    8
`define STAT_SEQ_HI    11

// sampled monitor: 2**11 = 2048 is the largest divide
`define SMP_MAX_SEL    4'hb
`define FRC_4MHZ       2'h0

// interrupt bits
`define IRQ_MON_LOW    0
`define IRQ_WAKE       1
`define IRQ_RESET      2

// timing
`define CLK_PERIOD_NS  4
`define RST_HOLD_NS    1000
`define RST_HOLD_CYC   ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> inc/supply_reset_sequencer_pkg.sv
package supply_reset_sequencer_pkg;

	typedef enum logic [3:0] {
		st_off    = 4'h1,
		st_settle = 4'h2,
		st_run    = 4'h4,
		st_low    = 4'h8
	} seq_state_t;

	typedef enum logic [2:0] {
		cause_general  = 3'h0,
		cause_wakeup   = 3'h1,
		cause_software = 3'h2,
		cause_user     = 3'h3,
		cause_watchdog = 3'h4
	} cause_t;

	typedef struct packed {
		logic backup_low;
		logic core_low;
		logic usb_phy_low;
	} supply_sense_t;

	typedef struct packed {
		seq_state_t  seq;
		logic [15:0] cnt;
		cause_t      cause;
		logic [31:0] mode;
		logic [15:0] wake_en;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_en;
		logic        a_wr;
		logic [7:0]  a_addr;
		logic [31:0] rdata;
		logic [10:0] smp_cnt;
		logic        mon_low;
	} state_t;

endpackage : supply_reset_sequencer_pkg

// >>> hw/supply_reset_sequencer.sv
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "supply_reset_sequencer_map.svh"

module supply_reset_sequencer
	import supply_reset_sequencer_pkg::*;
(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	input  wire supply_sense_t sense,
	input  wire logic [15:0]   wake_event,
	input  wire logic          watchdog_reset_req,
	input  wire logic          external_reset_pin_in,
	output logic               external_reset_pin_out,
	output logic               external_reset_pin_oe_n,
	output logic               chip_reset_n,
	output logic               core_reset_n,
	output logic               regulator_enable,
	output logic               core_clock_stop,
	output logic               rc_osc_enable,
	output logic               xtal_osc_enable,
	output logic               slow_clk_xtal,
	output logic [1:0]         master_clock_frc_sel,
	output logic               usb_phy_monitor_enable,
	output logic [3:0]         usb_phy_monitor_threshold,
	output logic               irq
);

	state_t      r;
	state_t      next_r;
	logic        ap;
	logic        bod_on;
	logic        bod_trip;
	logic        sw_rst;
	logic        lp_req;
	logic        wake_hit;
	logic        mon_on;
	logic [2:0]  clr;
	logic [2:0]  ev;
	logic [3:0]  smp_sel;
	logic [10:0] smp_mask;

	////////////////////////////////////////////////////////////////////////////////
	// combinational status

	assign bod_on   = !r.mode[`MODE_BOD_DIS];
	assign bod_trip = bod_on && sense.core_low;
	assign wake_hit = |(wake_event & r.wake_en);
	assign smp_sel  = (r.mode[`MODE_SMP_HI:`MODE_SMP_LO] > `SMP_MAX_SEL) ?
		`SMP_MAX_SEL : r.mode[`MODE_SMP_HI:`MODE_SMP_LO];
	assign smp_mask = (11'h1 << smp_sel) - 11'h1;
	// sampled mode: monitor on one cycle in 2**sel
	assign mon_on   = r.mode[`MODE_MON_EN] &&
		(smp_sel == 4'h0 || (r.smp_cnt & smp_mask) == 11'h0);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_r = r;
		ap     = hsel && htrans[1] && hready;
		sw_rst = 1'b0;
		lp_req = 1'b0;
		clr    = 3'h0;
		ev     = 3'h0;

		next_r.a_wr   = ap && hwrite;
		next_r.a_addr = haddr[7:0];

		// read data captured in the address phase
		if (ap && !hwrite) begin
			unique case (haddr[7:0])
				`OFS_MODE:     next_r.rdata = r.mode;
				`OFS_STATUS: begin
					next_r.rdata = 32'h0;
					next_r.rdata[`STAT_CAUSE_HI:0] = r.cause;
					next_r.rdata[`STAT_MON_LOW] = r.mon_low;
					next_r.rdata[`STAT_SLOW_XTAL] = r.mode[`MODE_SLOW_XTAL];
					next_r.rdata[`STAT_SEQ_HI:`STAT_SEQ_LO] = r.seq;
				end
				`OFS_WAKE_EN:  next_r.rdata = {16'h0, r.wake_en};
				`OFS_IRQ_STAT: next_r.rdata = {29'h0, r.irq_stat};
				`OFS_IRQ_EN:   next_r.rdata = {29'h0, r.irq_en};
				default:       next_r.rdata = 32'h0;
			endcase
		end

		// writes in the data phase
		if (r.a_wr) begin
			unique case (r.a_addr)
				`OFS_MODE: next_r.mode = (hwdata & `MODE_WMASK) |
					(r.mode & `MODE_STICKY);
				`OFS_CTRL: begin
					sw_rst = hwdata[`CTRL_SW_RST];
					lp_req = hwdata[`CTRL_LP_ENTER];
				end
				`OFS_WAKE_EN: next_r.wake_en = hwdata[15:0];
				`OFS_IRQ_CLR: clr = hwdata[2:0];
				`OFS_IRQ_EN:  next_r.irq_en = hwdata[2:0];
				default: ;
			endcase
		end

		// supply monitor sampling
		next_r.smp_cnt = r.smp_cnt + 11'h1;
		if (!r.mode[`MODE_MON_EN]) begin
			next_r.mon_low = 1'b0;
		end else if (mon_on) begin
			next_r.mon_low = sense.usb_phy_low;
		end
		ev[`IRQ_MON_LOW] = mon_on && sense.usb_phy_low;

		// start-up and low-power sequencer
		unique case (r.seq)
			st_off: begin
				next_r.seq = st_settle;
				next_r.cnt = 16'h0;
			end
			st_settle: begin
				if (r.cnt == 16'(`RST_HOLD_CYC - 1)) begin
					next_r.seq = st_run;
				end else begin
					next_r.cnt = r.cnt + 16'h1;
				end
			end
			st_run: begin
				if (lp_req) begin
					next_r.seq = st_low;
				end
			end
			st_low: begin
				if (wake_hit) begin
					ev[`IRQ_WAKE] = 1'b1;
					if (r.mode[`MODE_LP_BACKUP]) begin
						next_r.seq   = st_settle;
						next_r.cnt   = 16'h0;
						next_r.cause = cause_wakeup;
					end else begin
						next_r.seq = st_run;
					end
				end
			end
		endcase

		// reset sources, highest first; cause changes here and on a wake from low power with MODE_LP_BACKUP set
		if (sense.backup_low) begin
			next_r.seq   = st_off;
			next_r.cause = cause_general;
		end else if (bod_trip && r.seq != st_off) begin
			next_r.seq   = st_settle;
			next_r.cnt   = 16'h0;
			next_r.cause = cause_general;
		end else if (r.seq == st_run) begin
			if (watchdog_reset_req) begin
				next_r.seq   = st_settle;
				next_r.cnt   = 16'h0;
				next_r.cause = cause_watchdog;
			end else if (sw_rst) begin
				next_r.seq   = st_settle;
				next_r.cnt   = 16'h0;
				next_r.cause = cause_software;
			end else if (!external_reset_pin_in) begin
				next_r.seq   = st_settle;
				next_r.cnt   = 16'h0;
				next_r.cause = cause_user;
			end
		end

		ev[`IRQ_RESET] = next_r.seq == st_settle && r.seq != st_settle;
		// set wins over clear
		next_r.irq_stat = (r.irq_stat & ~clr) | ev;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register, own power-on reset

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r          <= '0;
			r.seq      <= st_off;
			r.cause    <= cause_general;
			r.mode     <= `MODE_RESET;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = r.rdata;

	assign chip_reset_n     = !sense.backup_low;
	assign regulator_enable = r.seq != st_off &&
		!(r.seq == st_low && r.mode[`MODE_LP_BACKUP]);
	assign core_reset_n     = (r.seq == st_run || r.seq == st_low) &&
		!bod_trip && !sense.backup_low;
	assign core_clock_stop  = r.seq == st_low;

	// open drain: pin pulled low while the core reset pulse lasts
	assign external_reset_pin_out  = 1'b0;
	assign external_reset_pin_oe_n = !(r.seq == st_off || r.seq == st_settle);

	assign slow_clk_xtal   = r.mode[`MODE_SLOW_XTAL];
	assign rc_osc_enable   = !r.mode[`MODE_SLOW_XTAL];
	assign xtal_osc_enable = r.mode[`MODE_XTAL_EN] || r.mode[`MODE_SLOW_XTAL];

	assign master_clock_frc_sel = r.mode[`MODE_FRC_HI:`MODE_FRC_LO];

	assign usb_phy_monitor_enable    = mon_on;
	assign usb_phy_monitor_threshold = r.mode[`MODE_THR_HI:`MODE_THR_LO];

	assign irq = |(r.irq_stat & r.irq_en);

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	property p_backup_reset;
		@(posedge hclk) disable iff (!hresetn)
		sense.backup_low |-> !chip_reset_n && !core_reset_n ##1 !regulator_enable;
	endproperty
	a_backup_reset: assert property (p_backup_reset)
		else $error("backup supply low did not reset the chip");

	property p_bod_default;
		@(posedge hclk) disable iff (!hresetn)
		$past(r.seq) == st_off && $past(r.cause) == cause_general &&
		r.seq == st_settle && r.cnt == 16'h0 && $past(r.mode) == `MODE_RESET |-> bod_on;
	endproperty
	a_bod_default: assert property (p_bod_default)
		else $error("brownout detector not enabled after reset");

	property p_bod_trip;
		@(posedge hclk) disable iff (!hresetn)
		bod_on && sense.core_low && !sense.backup_low && r.seq != st_off
		|-> !core_reset_n ##1 r.seq == st_settle && r.cnt == 16'h0;
	endproperty
	a_bod_trip: assert property (p_bod_trip)
		else $error("core brownout did not assert core reset");

	property p_mon_off;
		@(posedge hclk) disable iff (!hresetn)
		!r.mode[`MODE_MON_EN] |-> !usb_phy_monitor_enable;
	endproperty
	a_mon_off: assert property (p_mon_off)
		else $error("usb supply monitor active while disabled");

	property p_sample;
		@(posedge hclk) disable iff (!hresetn)
		usb_phy_monitor_enable && smp_sel == `SMP_MAX_SEL && $stable(r.mode)
		|=> (!usb_phy_monitor_enable || smp_sel != `SMP_MAX_SEL) [*8];
	endproperty
	a_sample: assert property (p_sample)
		else $error("sampled monitor enabled too often");

	property p_watchdog_cause;
		@(posedge hclk) disable iff (!hresetn)
		r.seq == st_run && watchdog_reset_req && !sense.backup_low && !bod_trip
		|=> r.cause == cause_watchdog && r.seq == st_settle && !core_reset_n;
	endproperty
	a_watchdog_cause: assert property (p_watchdog_cause)
		else $error("watchdog reset cause not recorded");

	property p_pin_pulse;
		@(posedge hclk) disable iff (!hresetn)
		$rose(r.seq == st_settle) && !sense.backup_low && !bod_trip
		|-> !external_reset_pin_oe_n && !external_reset_pin_out [*8];
	endproperty
	a_pin_pulse: assert property (p_pin_pulse)
		else $error("external reset pin not driven during reset pulse");

	property p_osc_excl;
		@(posedge hclk) disable iff (!hresetn)
		rc_osc_enable != slow_clk_xtal && (!slow_clk_xtal || xtal_osc_enable);
	endproperty
	a_osc_excl: assert property (p_osc_excl)
		else $error("slow clock oscillator selection inconsistent");

	property p_reg_first;
		@(posedge hclk) disable iff (!hresetn)
		$rose(core_reset_n) |-> $past(regulator_enable, 8);
	endproperty
	a_reg_first: assert property (p_reg_first)
		else $error("core reset released before regulator enabled");

	property p_wake;
		@(posedge hclk) disable iff (!hresetn)
		r.seq == st_low && wake_hit && !sense.backup_low && !bod_trip
		|=> r.seq != st_low && r.irq_stat[`IRQ_WAKE];
	endproperty
	a_wake: assert property (p_wake)
		else $error("enabled wake event did not leave low power");

	property p_cause_hold;
		@(posedge hclk) disable iff (!hresetn)
		$stable(r.seq) && r.seq != st_settle |-> $stable(r.cause);
	endproperty
	a_cause_hold: assert property (p_cause_hold)
		else $error("reset cause changed without a reset");

	c_run: cover property (@(posedge hclk) disable iff (!hresetn)
		r.seq == st_settle ##1 r.seq == st_run);
	c_user: cover property (@(posedge hclk) disable iff (!hresetn)
		r.seq == st_run && !external_reset_pin_in ##1 r.cause == cause_user);
	c_backup_wake: cover property (@(posedge hclk) disable iff (!hresetn)
		r.seq == st_low && !regulator_enable ##1 r.cause == cause_wakeup);
	c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));

endmodule : supply_reset_sequencer

`default_nettype wire

// >>> test/supply_rails_model.sv
`timescale 1ns/1ns
`default_nettype none

module supply_rails_model
	import supply_reset_sequencer_pkg::*;
(
	input  wire logic         drop_backup,
	input  wire logic         drop_core,
	input  wire logic         drop_usb,
	input  wire logic         press,
	input  wire logic         pin_out,
	input  wire logic         pin_oe_n,
	output var supply_sense_t sense,
	output logic              pin_level
);
	assign sense = '{backup_low: drop_backup, core_low: drop_core, usb_phy_low: drop_usb};
	// pulled-up pin, low when driven or button held
	assign pin_level = !((!pin_oe_n && !pin_out) || press);
endmodule : supply_rails_model

`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "supply_reset_sequencer_map.svh"

module tb
	import supply_reset_sequencer_pkg::*;
;
	logic          hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, wdog = 0, press = 0;
	logic          d_b = 0, d_c = 0, d_u = 0, rdy, hresp, pin_out, oe_n, pin_lvl, chip_n, core_n;
	logic          reg_en, clk_stop, rc_en, xt_en, slow_xt, mon_en, irq;
	logic [1:0]    htrans = 0, frc;
	logic [3:0]    thr;
	logic [15:0]   wake = 0;
	logic [31:0]   haddr = 0, hwdata = 0, hrdata, rd, lq = 32'h0483b249, mode;
	supply_sense_t sense;
	int            n_mismatch = 0, comparisons = 0, n, k;

	always #2 hclk = ~hclk;

	supply_rails_model i_rails (.drop_backup(d_b), .drop_core(d_c), .drop_usb(d_u),
		.press(press), .pin_out(pin_out), .pin_oe_n(oe_n), .sense(sense), .pin_level(pin_lvl));

	supply_reset_sequencer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
		.hreadyout(rdy), .hresp(hresp), .hrdata(hrdata), .sense(sense), .wake_event(wake),
		.watchdog_reset_req(wdog), .external_reset_pin_in(pin_lvl),
		.external_reset_pin_out(pin_out), .external_reset_pin_oe_n(oe_n),
		.chip_reset_n(chip_n), .core_reset_n(core_n), .regulator_enable(reg_en),
		.core_clock_stop(clk_stop), .rc_osc_enable(rc_en), .xtal_osc_enable(xt_en),
		.slow_clk_xtal(slow_xt), .master_clock_frc_sel(frc), .usb_phy_monitor_enable(mon_en),
		.usb_phy_monitor_threshold(thr), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function logic [31:0] exp_on(input logic [3:0] sel);
		return 32'd4096 >> ((sel > 4'hb) ? 4'hb : sel);
	endfunction : exp_on

	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task edge_rdy;
		int i;
		i = 0;
		@(posedge hclk);
		while (rdy !== 1'b1) begin
			if (++i > 50) begin
				n_mismatch++;
				tally_and_finish;
			end
			@(posedge hclk);
		end
	endtask : edge_rdy

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		edge_rdy;
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy;
		rd = hrdata;
		@(negedge hclk);
	endtask : bus

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(0, a, 32'h0);
		check("register", rd, exp);
	endtask : rdchk

	// counts falling edges until core reset reaches lvl
	task wait_core(input logic lvl);
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (core_n !== lvl && n < 2000);
		if (n >= 2000) begin
			n_mismatch++;
			tally_and_finish;
		end
	endtask : wait_core

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge hclk);
		check("regulator", reg_en, 0);
		check("pin oe", oe_n, 0);
		hresetn <= 1;
		wait_core(1);
		check("regulator", reg_en, 1);
		rdchk(`OFS_MODE, `MODE_RESET);
		check("clocks", {mon_en, rc_en, xt_en, slow_xt}, 4'h4);
		check("frc", frc, `FRC_4MHZ);
		rdchk(`OFS_STATUS, 32'h400);
		rdchk(8'h40, 32'h0);
		@(posedge hclk);
		wdog <= 1;
		@(posedge hclk);
		wdog <= 0;
		wait_core(0);
		check("pin oe", oe_n, 0);
		wait_core(1);
		check("settle", n, `RST_HOLD_CYC);
		rdchk(`OFS_STATUS, 32'h404);
		rdchk(`OFS_IRQ_STAT, 32'h4);
		rdchk(`OFS_STATUS, 32'h404);
		bus(1, `OFS_CTRL, 32'h1);
		wait_core(0);
		wait_core(1);
		rdchk(`OFS_STATUS, 32'h402);
		@(posedge hclk);
		press <= 1;
		wait_core(0);
		check("pin level", pin_lvl, 0);
		@(posedge hclk);
		press <= 0;
		wait_core(1);
		rdchk(`OFS_STATUS, 32'h403);
		@(posedge hclk);
		d_c <= 1;
		@(negedge hclk);
		check("core reset", core_n, 0);
		@(posedge hclk);
		d_c <= 0;
		wait_core(1);
		rdchk(`OFS_STATUS, 32'h400);
		bus(1, `OFS_MODE, 32'h1);
		@(posedge hclk);
		d_c <= 1;
		repeat (5) @(negedge hclk);
		check("core reset", core_n, 1);
		@(posedge hclk);
		d_c <= 0;
		for (int j = 0; j < 4; j++) begin
			lq = lfsr(lq);
			k = (j == 0) ? 0 : (j == 1) ? 1 + lq[7:4] % 10 : 11 + 4 * (j - 2);
			mode = 32'h3 | {lq[3:0], 4'h0} | (k << 8);
			bus(1, `OFS_MODE, mode);
			check("threshold", thr, lq[3:0]);
			n = 0;
			repeat (4096) begin
				@(negedge hclk);
				n += mon_en;
			end
			check("samples", n, exp_on(k[3:0]));
		end
		bus(1, `OFS_MODE, 32'h3);
		bus(1, `OFS_IRQ_EN, 32'h1);
		@(posedge hclk);
		d_u <= 1;
		repeat (4) @(negedge hclk);
		check("irq", irq, 1);
		rdchk(`OFS_STATUS, 32'h410);
		bus(1, `OFS_IRQ_EN, 32'h0);
		check("irq", irq, 0);
		@(posedge hclk);
		d_u <= 0;
		bus(1, `OFS_IRQ_CLR, 32'h1);
		bus(1, `OFS_IRQ_EN, 32'h1);
		check("irq", irq, 0);
		bus(1, `OFS_MODE, 32'h1001);
		bus(1, `OFS_MODE, 32'h3001);
		check("slow osc", {rc_en, xt_en, slow_xt}, 3'h3);
		bus(1, `OFS_MODE, 32'h1001);
		rdchk(`OFS_MODE, 32'h3001);
		lq = lfsr(lq);
		k = lq[3:0];
		bus(1, `OFS_WAKE_EN, 32'h1 << k);
		bus(1, `OFS_IRQ_EN, 32'h2);
		bus(1, `OFS_CTRL, 32'h2);
		repeat (2) @(negedge hclk);
		check("clock stop", clk_stop, 1);
		@(posedge hclk);
		wake <= ~(16'h1 << k);
		repeat (3) @(negedge hclk);
		check("clock stop", clk_stop, 1);
		@(posedge hclk);
		wake <= 16'h1 << k;
		repeat (3) @(negedge hclk);
		check("wake", {clk_stop, irq}, 2'h1);
		@(posedge hclk);
		wake <= 0;
		bus(1, `OFS_MODE, 32'h13001);
		bus(1, `OFS_CTRL, 32'h2);
		repeat (2) @(negedge hclk);
		check("regulator", reg_en, 0);
		@(posedge hclk);
		wake <= 16'h1 << k;
		wait_core(0);
		@(posedge hclk);
		wake <= 0;
		wait_core(1);
		rdchk(`OFS_STATUS, 32'h421);
		@(posedge hclk);
		d_b <= 1;
		@(negedge hclk);
		check("chip reset", {chip_n, core_n}, 2'h0);
		@(posedge hclk);
		d_b <= 0;
		wait_core(1);
		rdchk(`OFS_STATUS, 32'h420);
		tally_and_finish;
	end
endmodule : tb

`default_nettype wire
